// ---- bench/dsr_ser_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsr_ser_model (
    input  wire logic       link_clk,
    input  wire logic       run,
    input  wire logic [2:0] dead,
    output logic            clock_lane,
    output logic      [2:0] lanes
);
    dsr_pkg::dsr_word_type q_word[$];
    logic [2:0]            q_inv[$];
    logic                  long_hi;
    task automatic push(input dsr_pkg::dsr_word_type w, input logic [2:0] inv);
        q_word.push_back(w);
        q_inv.push_back(inv);
    endtask : push
    // empty queue sends zero words so the stream never stalls
    task automatic send_one();
        dsr_pkg::dsr_word_type w;
        logic [2:0]            inv;
        logic [8:0]            sym [3];
        w = '0;
        inv = 3'h0;
        if (q_word.size() > 0) begin
            w = q_word.pop_front();
            inv = q_inv.pop_front();
        end
        for (int l = 0; l < 3; l++) begin
            sym[l][6:0] = inv[l] ? ~w[l*7 +: 7] : w[l*7 +: 7];
            sym[l][8:7] = inv[l] ? 2'h2 : 2'h1;
        end
        long_hi = ~long_hi;
        for (int b = 0; b < 9; b++) begin
            if (b > 0) @(negedge link_clk);
            clock_lane = (b < (long_hi ? 5 : 4));
            for (int l = 0; l < 3; l++) lanes[l] = sym[l][b] & ~dead[l];
        end
    endtask : send_one
    initial begin
        clock_lane = 1'b0;
        lanes = 3'h0;
        long_hi = 1'b0;
        forever begin
            @(negedge link_clk);
            if (run) send_one();
            else begin
                clock_lane = 1'b0;
                // idle data lanes not marked dead keep moving so stale bits never look valid; dead lanes stay low
                lanes = ~lanes & ~dead;
            end
        end
    end
endmodule : dsr_ser_model
`default_nettype wire

// ---- bench/dsr_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsr_top_sva #(
    parameter int LOCK_PERIODS = 8
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  active_low_enable_input,
    input wire logic                  link_clock_input,
    input wire dsr_pkg::dsr_word_type parallel_data_outputs,
    input wire logic                  parallel_data_oe,
    input wire logic                  recovered_clock_output,
    input wire logic                  recovered_clock_oe,
    input wire logic                  lock_status
);
    logic        lane_q;
    logic        lane_d;
    logic [7:0]  idle_q;
    logic [7:0]  idle_d;
    logic [15:0] rise_q;
    logic [15:0] rise_d;
    // rise count over-counts vs the design, so a lower bound on it is safe
    always_comb begin
        lane_d = link_clock_input;
        idle_d = (idle_q == 8'hff) ? idle_q : idle_q + 8'h01;
        rise_d = rise_q;
        if (lane_d != lane_q) idle_d = 8'h00;
        if (!active_low_enable_input || lock_status || idle_q >= 8'h46) rise_d = 16'h0000;
        else if (lane_d && !lane_q) rise_d = rise_q + 16'h0001;
        if (!rst_n) begin
            idle_d = 8'h00;
            rise_d = 16'h0000;
        end
    end
    always_ff @(posedge clk) begin
        lane_q <= lane_d;
        idle_q <= idle_d;
        rise_q <= rise_d;
    end
    oe_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !active_low_enable_input [*5] |-> !parallel_data_oe) else $error("driven while off");
    oe_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        parallel_data_oe == recovered_clock_oe) else $error("enables differ");
    en_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(active_low_enable_input) ##1 active_low_enable_input [*4] |-> parallel_data_oe)
        else $error("outputs not driven after enable");
    acq_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!lock_status && parallel_data_oe) [*2] |-> parallel_data_outputs == '0)
        else $error("data passed while unlocked");
    acq_rclk_a: assert property (@(posedge clk) disable iff (!rst_n)
        !lock_status [*2] |-> !recovered_clock_output) else $error("strobe while unlocked");
    loss_a: assert property (@(posedge clk) disable iff (!rst_n)
        idle_q == 8'h46 |-> !lock_status && (!parallel_data_oe || parallel_data_outputs == '0))
        else $error("clock loss not seen");
    lock_early_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(lock_status) |-> rise_q >= LOCK_PERIODS) else $error("lock too early");
    lock_late_a: assert property (@(posedge clk) disable iff (!rst_n)
        rise_q == LOCK_PERIODS + 4 |-> ##[0:40] lock_status) else $error("lock too late");
    strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(recovered_clock_output) |-> $stable(parallel_data_outputs))
        else $error("data moved at strobe");
endmodule : dsr_top_sva
bind dsr_top dsr_top_sva #(.LOCK_PERIODS(LOCK_PERIODS)) i_dsr_top_sva (
    .clk(clk),
    .rst_n(rst_n),
    .active_low_enable_input(active_low_enable_input),
    .link_clock_input(link_clock_input),
    .parallel_data_outputs(parallel_data_outputs),
    .parallel_data_oe(parallel_data_oe),
    .recovered_clock_output(recovered_clock_output),
    .recovered_clock_oe(recovered_clock_oe),
    .lock_status(lock_status)
);
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                  clk;
    logic                  rst_n;
    logic                  link_clk;
    logic                  enable;
    logic                  run;
    logic [2:0]            dead;
    logic                  clock_lane;
    logic [2:0]            lanes;
    dsr_pkg::dsr_word_type data_out;
    logic                  data_oe;
    logic                  rclk;
    logic                  rclk_oe;
    logic                  locked;
    logic                  rclk_was;
    dsr_pkg::dsr_word_type rx[$];
    int                    error_cnt;
    int                    checks_done;
    int                    lhalf;
    dsr_top #(.LOCK_PERIODS(8)) i_dsr_top (
        .clk(clk),
        .rst_n(rst_n),
        .link_clk(link_clk),
        .active_low_enable_input(enable),
        .link_clock_input(clock_lane),
        .serial_lane_inputs(lanes),
        .parallel_data_outputs(data_out),
        .parallel_data_oe(data_oe),
        .recovered_clock_output(rclk),
        .recovered_clock_oe(rclk_oe),
        .lock_status(locked)
    );
    dsr_ser_model i_dsr_ser_model (.link_clk(link_clk), .run(run), .dead(dead),
        .clock_lane(clock_lane), .lanes(lanes));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        lhalf = 32;
        #7;
        forever #(lhalf) link_clk = ~link_clk;
    end
    // strobe edges looked at half a cycle later, when outputs have settled
    always @(negedge clk) begin
        if (rclk === 1'b1 && rclk_was === 1'b0 && locked === 1'b1 && data_out !== '0) begin
            rx.push_back(data_out);
        end
        rclk_was = rclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic wait_lock();
        int n;
        n = 0;
        while (locked !== 1'b1 && n < 600) begin
            cyc(1);
            n++;
        end
        check(32'(locked), 32'h1);
    endtask : wait_lock
    function automatic dsr_pkg::dsr_word_type word_of(input int i);
        word_of.lane0 = 7'(i + 1);
        word_of.lane1 = 7'h7f ^ 7'(i * 9);
        word_of.lane2 = 7'h55 ^ 7'(i * 17);
    endfunction : word_of
    // every flag combination across the three lanes, dead lanes 1 and 2 expected low
    task automatic t_burst(input logic [2:0] dmask);
        dsr_pkg::dsr_word_type w;
        rx.delete();
        for (int i = 0; i < 8; i++) i_dsr_ser_model.push(word_of(i), 3'(i));
        cyc(180);
        check(32'(rx.size()), 32'h8);
        for (int i = 0; i < 8 && i < rx.size(); i++) begin
            w = word_of(i);
            if (dmask[1]) w.lane1 = 7'h00;
            if (dmask[2]) w.lane2 = 7'h00;
            check(32'(rx[i]), 32'(w));
        end
    endtask : t_burst
    task automatic t_first_lock();
        check(32'(data_oe), 32'h0);
        run = 1'b1;
        cyc(30);
        check(32'(data_oe), 32'h0);
        enable = 1'b1;
        cyc(4);
        check(32'(data_oe), 32'h1);
        cyc(40);
        check(32'(locked), 32'h0);
        check(32'(data_out), 32'h0);
        wait_lock();
    endtask : t_first_lock
    task automatic t_loss();
        run = 1'b0;
        cyc(100);
        check(32'(locked), 32'h0);
        check(32'(data_out), 32'h0);
        run = 1'b1;
        cyc(50);
        check(32'(locked), 32'h0);
        wait_lock();
        t_burst(3'h0);
    endtask : t_loss
    task automatic t_rate();
        lhalf = 20;
        cyc(20);
        wait_lock();
        t_burst(3'h0);
        lhalf = 32;
    endtask : t_rate
    task automatic t_pwrdn();
        enable = 1'b0;
        cyc(5);
        check(32'(data_oe), 32'h0);
        check(32'(rclk_oe), 32'h0);
        check(32'(locked), 32'h0);
        run = 1'b0;
        cyc(2);
        enable = 1'b1;
        cyc(20);
        check(32'(data_oe), 32'h1);
        check(32'(data_out), 32'h0);
        run = 1'b1;
        wait_lock();
        t_burst(3'h0);
    endtask : t_pwrdn
    initial begin
        error_cnt = 0;
        checks_done = 0;
        rst_n = 1'b0;
        enable = 1'b0;
        run = 1'b0;
        dead = 3'h0;
        cyc(16);
        rst_n = 1'b1;
        cyc(2);
        t_first_lock();
        t_burst(3'h0);
        dead = 3'h6;
        t_burst(3'h6);
        dead = 3'h0;
        t_loss();
        t_rate();
        t_pwrdn();
        give_verdict();
    end
    // whole run is about 1400 cycles
    initial begin
        repeat (8000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire

// ---- rtl/dsr_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsr_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    always_comb begin
        in_ready  = (cnt_q != FULL_CNT);
        out_valid = (cnt_q != '0);
        out_data  = mem_q[rd_q];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        mem_d     = mem_q;
        wr_d      = wr_q;
        rd_d      = rd_q;
        cnt_d     = cnt_q;
        if (flush) begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end else begin
            if (push) begin
                mem_d[wr_q] = in_data;
                wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk) begin
        mem_q <= mem_d;
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : dsr_fifo
`default_nettype wire

// ---- rtl/dsr_pkg.sv ----
`default_nettype none
package dsr_pkg;
    // lane framing
    localparam int          LANES         = 3;
    localparam int          BITS_PER_WORD = 9;
    localparam int          DATA_BITS     = 7;
    localparam int          WORD_BITS     = LANES * DATA_BITS;
    localparam int          FLAG_LSB      = 7;
    localparam int          FLAG_MSB      = 8;
    localparam logic [1:0]  FLAG_PLAIN    = 2'h1;
    localparam logic [1:0]  FLAG_INVERTED = 2'h2;
    localparam int          BIT_CNT_W     = 4;
    localparam logic [3:0]  BIT_FIRST     = 4'h1;
    localparam logic [3:0]  BIT_LAST      = 4'h8;
    localparam logic [3:0]  BIT_CNT_SAT   = 4'h9;

    // timing
    localparam int          SYS_PERIOD_NS = 50;
    localparam int          LOSS_TIME_NS  = 2000;
    localparam int          LOSS_CYCLES_RAW = LOSS_TIME_NS / SYS_PERIOD_NS;
    localparam int          LOSS_CYCLES   = (LOSS_CYCLES_RAW < 1) ? 1 : LOSS_CYCLES_RAW;
    localparam int          LOSS_CNT_W    = $clog2(LOSS_CYCLES + 1);
    localparam int          LOCK_PERIODS  = 32800;
    localparam int          MUX_GAP_NS    = 100;

    // output path
    localparam int          FIFO_DEPTH    = 32;
    localparam int          OUT_DIV       = 4;

    typedef struct packed {
        logic [DATA_BITS-1:0] lane2;
        logic [DATA_BITS-1:0] lane1;
        logic [DATA_BITS-1:0] lane0;
    } dsr_word_type;

    typedef struct packed {
        logic             clk_lane;
        logic [LANES-1:0] data;
    } dsr_pins_type;

    typedef enum logic [2:0] {
        ST_OFF  = 3'h1,
        ST_ACQ  = 3'h2,
        ST_LOCK = 3'h4
    } dsr_state_type;
endpackage : dsr_pkg
`default_nettype wire

// ---- rtl/dsr_top.sv ----
// Overview of operation
// - clock lane stopped or too slow forces every parallel output low.
// - enable low puts parallel outputs in high impedance and halts the sampler.
// - after enable, and while acquiring lock, parallel outputs are driven low.
// - lock declared after an internal count of at most 32,800 link periods.
// - no ordering needed between link clock, enable and supply to lock.
// - only the balanced coding mode exists; no mode select input.
// - link rate may change on the fly; lock follows without power cycling.
// - each lane carries nine bit times per link clock period.
// - a lane held static low yields that lane's outputs low and quiet.
// - seven data bits plus two complementary flags; flagged words are re-inverted.
// - twenty-one outputs, seven per lane, lane 0 in the lowest group.
// - recovered clock strobe edge is fixed per variant, rising or falling.
`timescale 1ns/1ps
`default_nettype none
module dsr_top #(
    parameter int   LOCK_PERIODS = dsr_pkg::LOCK_PERIODS,
    parameter int   FIFO_DEPTH   = dsr_pkg::FIFO_DEPTH,
    parameter int   OUT_DIV      = dsr_pkg::OUT_DIV,
    parameter logic STROBE_RISE  = 1'b1
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         link_clk,
    input  wire logic                         active_low_enable_input,
    input  wire logic                         link_clock_input,
    input  wire logic [dsr_pkg::LANES-1:0]    serial_lane_inputs,
    output dsr_pkg::dsr_word_type             parallel_data_outputs,
    output logic                              parallel_data_oe,
    output logic                              recovered_clock_output,
    output logic                              recovered_clock_oe,
    output logic                              lock_status
);
    localparam int LOCK_W = $clog2(LOCK_PERIODS + 1);
    localparam int DIV_W  = $clog2(OUT_DIV + 1);
    localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_PERIODS - 1);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(OUT_DIV - 1);
    localparam logic [DIV_W-1:0]  DIV_HALF  = DIV_W'(OUT_DIV / 2);
    localparam logic [dsr_pkg::LOSS_CNT_W-1:0] LOSS_MAX =
        dsr_pkg::LOSS_CNT_W'(dsr_pkg::LOSS_CYCLES);

    // ---------------- link domain ----------------
    dsr_pkg::dsr_pins_type pin_meta_q, pin_sync_q;
    logic                  en_lmeta_q, en_lsync_q;
    logic                  clk_prev_q, clk_prev_d;
    logic [dsr_pkg::BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
    logic [dsr_pkg::BITS_PER_WORD-1:0] sh_q [dsr_pkg::LANES];
    logic [dsr_pkg::BITS_PER_WORD-1:0] sh_d [dsr_pkg::LANES];
    logic [dsr_pkg::WORD_BITS-1:0] lword_q, lword_d, lword_new;
    logic                  ltog_q, ltog_d;
    logic                  frame_start, word_done;

    // pins are outside any domain, so two flops before use
    always_ff @(posedge link_clk) begin
        pin_meta_q <= {link_clock_input, serial_lane_inputs};
        pin_sync_q <= pin_meta_q;
        en_lmeta_q <= active_low_enable_input;
        en_lsync_q <= en_lmeta_q;
    end

    function automatic logic [dsr_pkg::DATA_BITS-1:0] restore(
        input logic [dsr_pkg::BITS_PER_WORD-1:0] w
    );
        // undefined flag pairs pass as plain, so a static low lane gives zeros
        if (w[dsr_pkg::FLAG_MSB:dsr_pkg::FLAG_LSB] == dsr_pkg::FLAG_INVERTED) begin
            restore = ~w[dsr_pkg::DATA_BITS-1:0];
        end else begin
            restore = w[dsr_pkg::DATA_BITS-1:0];
        end
    endfunction : restore

    // clock lane rising edge marks bit 0 of every word
    assign frame_start = pin_sync_q.clk_lane && !clk_prev_q;
    assign word_done   = !frame_start && (bit_cnt_q == dsr_pkg::BIT_LAST);

    generate
        for (genvar g = 0; g < dsr_pkg::LANES; g++) begin : g_lane
            always_comb begin
                sh_d[g] = {pin_sync_q.data[g], sh_q[g][dsr_pkg::BITS_PER_WORD-1:1]};
                lword_new[g*dsr_pkg::DATA_BITS +: dsr_pkg::DATA_BITS] = restore(sh_d[g]);
            end
        end
    endgenerate

    always_comb begin
        clk_prev_d = pin_sync_q.clk_lane;
        lword_d    = lword_q;
        ltog_d     = ltog_q;
        if (frame_start) begin
            bit_cnt_d = dsr_pkg::BIT_FIRST;
        end else if (bit_cnt_q == dsr_pkg::BIT_CNT_SAT) begin
            bit_cnt_d = bit_cnt_q;
        end else begin
            bit_cnt_d = bit_cnt_q + 1'b1;
        end
        if (word_done) begin
            lword_d = lword_new;
            ltog_d  = !ltog_q;
        end
    end

    // enable low holds the sampler in reset, standing in for a halted pll
    always_ff @(posedge link_clk) begin
        if (!en_lsync_q) begin
            clk_prev_q <= 1'b1; // waking mid-high must not look like a word start
            bit_cnt_q  <= dsr_pkg::BIT_CNT_SAT;
            lword_q    <= '0;
            ltog_q     <= 1'b0;
            for (int i = 0; i < dsr_pkg::LANES; i++) begin
                sh_q[i] <= '0;
            end
        end else begin
            clk_prev_q <= clk_prev_d;
            bit_cnt_q  <= bit_cnt_d;
            lword_q    <= lword_d;
            ltog_q     <= ltog_d;
            sh_q       <= sh_d;
        end
    end

    // ---------------- system domain ----------------
    logic en_meta_q, en_sync_q;
    logic tog_meta_q, tog_sync_q, tog_prev_q;
    logic word_evt;

    always_ff @(posedge clk) begin
        en_meta_q  <= active_low_enable_input;
        en_sync_q  <= en_meta_q;
        tog_meta_q <= ltog_q;
        tog_sync_q <= tog_meta_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tog_prev_q <= 1'b0;
        end else begin
            tog_prev_q <= tog_sync_q;
        end
    end

    // word stays held in the link domain for nine link cycles, long past the sync
    assign word_evt = tog_sync_q ^ tog_prev_q;

    // clock activity watch
    logic [dsr_pkg::LOSS_CNT_W-1:0] loss_cnt_q, loss_cnt_d;
    logic                           clk_lost;

    assign clk_lost = (loss_cnt_q == LOSS_MAX);

    always_comb begin
        if (word_evt || !en_sync_q) begin
            loss_cnt_d = '0;
        end else if (clk_lost) begin
            loss_cnt_d = loss_cnt_q;
        end else begin
            loss_cnt_d = loss_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loss_cnt_q <= '0;
        end else begin
            loss_cnt_q <= loss_cnt_d;
        end
    end

    // lock sequencing
    dsr_pkg::dsr_state_type state_q, state_d;
    logic [LOCK_W-1:0]      lock_cnt_q, lock_cnt_d;

    always_comb begin
        state_d    = state_q;
        lock_cnt_d = lock_cnt_q;
        case (state_q)
            dsr_pkg::ST_OFF: begin
                lock_cnt_d = '0;
                if (en_sync_q) begin
                    state_d = dsr_pkg::ST_ACQ;
                end
            end
            dsr_pkg::ST_ACQ: begin
                if (!en_sync_q) begin
                    state_d = dsr_pkg::ST_OFF;
                end else if (clk_lost) begin
                    lock_cnt_d = '0;
                end else if (word_evt) begin
                    if (lock_cnt_q == LOCK_LAST) begin
                        state_d = dsr_pkg::ST_LOCK;
                    end else begin
                        lock_cnt_d = lock_cnt_q + 1'b1;
                    end
                end
            end
            dsr_pkg::ST_LOCK: begin
                lock_cnt_d = '0;
                if (!en_sync_q) begin
                    state_d = dsr_pkg::ST_OFF;
                end else if (clk_lost) begin
                    state_d = dsr_pkg::ST_ACQ;
                end
            end
            default: begin
                state_d    = dsr_pkg::ST_OFF;
                lock_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q    <= dsr_pkg::ST_OFF;
            lock_cnt_q <= '0;
        end else begin
            state_q    <= state_d;
            lock_cnt_q <= lock_cnt_d;
        end
    end

    // capture stage feeding the fifo
    logic                          pend_valid_q, pend_valid_d;
    logic [dsr_pkg::WORD_BITS-1:0] pend_word_q, pend_word_d;
    logic                          fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [dsr_pkg::WORD_BITS-1:0] fifo_out_data;
    logic                          flush;

    assign flush = (state_q == dsr_pkg::ST_OFF);

    // a word arriving while the stage still waits on a full fifo is dropped
    always_comb begin
        pend_valid_d = pend_valid_q;
        pend_word_d  = pend_word_q;
        if (flush) begin
            pend_valid_d = 1'b0;
        end else if (word_evt && (!pend_valid_q || fifo_in_ready)) begin
            pend_valid_d = 1'b1;
            pend_word_d  = lword_q;
        end else if (fifo_in_ready) begin
            pend_valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_valid_q <= 1'b0;
            pend_word_q  <= '0;
        end else begin
            pend_valid_q <= pend_valid_d;
            pend_word_q  <= pend_word_d;
        end
    end

    dsr_fifo #(
        .WIDTH (dsr_pkg::WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (flush),
        .in_valid  (pend_valid_q),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_word_q),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // output pacing and strobe
    logic [DIV_W-1:0]      div_q, div_d;
    logic                  phase_q, phase_d;
    dsr_pkg::dsr_word_type data_q, data_d;
    logic                  oe_q, oe_d;
    logic                  rclk_q, rclk_d;
    logic                  lock_q, lock_d;
    logic                  locked;

    assign locked   = (state_q == dsr_pkg::ST_LOCK) && !clk_lost;
    assign fifo_pop = fifo_out_valid && (div_q == '0);

    always_comb begin
        div_d   = div_q;
        phase_d = phase_q;
        data_d  = data_q;
        oe_d    = en_sync_q;
        lock_d  = locked;
        if (div_q != '0) begin
            div_d = (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
            if (div_q == DIV_HALF) begin
                phase_d = 1'b1;
            end
        end else if (fifo_pop) begin
            div_d   = DIV_W'(1);
            phase_d = 1'b0;
            data_d  = dsr_pkg::dsr_word_type'(fifo_out_data);
        end
        if (!locked) begin
            data_d  = '0;
            phase_d = 1'b0;
        end
        // data moves on the inactive edge, the far chip latches on the active one
        rclk_d = locked && (STROBE_RISE ? phase_d : !phase_d);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_q   <= '0;
            phase_q <= 1'b0;
            data_q  <= '0;
            oe_q    <= 1'b0;
            rclk_q  <= 1'b0;
            lock_q  <= 1'b0;
        end else begin
            div_q   <= div_d;
            phase_q <= phase_d;
            data_q  <= data_d;
            oe_q    <= oe_d;
            rclk_q  <= rclk_d;
            lock_q  <= lock_d;
        end
    end

    assign parallel_data_outputs  = data_q;
    assign parallel_data_oe       = oe_q;
    assign recovered_clock_output = rclk_q;
    assign recovered_clock_oe     = oe_q;
    assign lock_status            = lock_q;
endmodule : dsr_top
`default_nettype wire
